// file: hdl/sodt_timer.sv
// Safe off-delay timer: contact decode, state machine, holdoff count and info words.
//
// What this block does
// R01: Delay input is interpreted as make (active high) or break (active low) contact.
// R02: After reset the delay input is disabled until configured.
// R03: Low delayed output is safe; driven low in safe and stop states.
// R04: Effective input high with run enable: run state, output high.
// R05: Input falling in run loads a nonzero holdoff and enters delay-out; a zero holdoff goes straight to safe.
// R06: Input low, holdoff not elapsed: delay-out, code 8, output high.
// R07: Input low, holdoff elapsed: safe state, code 3, output low.
// R08: Run enable false forces stop state and low output over everything.
// R09: Current state reported as 8-bit code: undefined, run, stop, safe, delay-out.
// R10: Diagnostic word of 16 bits always reads zero.
// R11: Error output is never asserted.
// R12: Base variant holdoff resolution is one tenth of a second.
// R13: Extended variant accepts holdoffs from 1 ms to 600 s.
// R14: Extended variant counts with a 1 ms or 10 ms tick.
// R15: 1 ms timebase counts 1 ms steps, limited to 60000 ms.
// R16: 10 ms timebase counts 10 ms steps, limited to 600000 ms.
// R17: Two options decide whether state and diagnostic words are copied each cycle.
// R18: Input returning high during holdoff keeps output high and returns to run.
// R19: Base variant limits the holdoff to 6000 ticks of 100 ms.
// R20: Extended timebase is 1 ms when the holdoff fits, else 10 ms.
`timescale 1ns/10ps
`include "sodt_cfg.svh"
module sodt_timer
  import sodt_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire logic          ce_i,
  // Cyclic function inputs.
  input  wire logic          delay_input_i,
  input  wire logic          block_run_enable_i,
  // Configuration.
  input  wire logic          cfg_load_i,
  input  wire sodt_contact_t cfg_contact_i,
  input  wire logic          cfg_extended_i,
  input  wire logic [19:0]   configured_holdoff_i,
  input  wire logic          expose_state_code_i,
  input  wire logic          expose_diagnostic_word_i,
  // Function outputs.
  output logic               delayed_output_o,
  output logic               error_o,
  output logic               holdoff_elapsed_flag_o,
  // Process image words.
  output logic [7:0]         state_code_o,
  output logic [15:0]        diagnostic_word_o
);
  sodt_tick_if  tk ();
  sodt_state_t  state;
  sodt_state_t  next_state;
  sodt_contact_t contact;
  logic         extended;
  logic [19:0]  holdoff;
  sodt_tb_t     tb_sel;
  logic [19:0]  remain;
  logic         sm_in;
  logic         sm_in_d;
  logic         fall;
  logic         elapsed;

  // ************************************************************
  // Helper functions
  // ************************************************************
  // State to 8-bit code; used by the image copy and by the checks.
  function automatic logic [7:0] state_code(input sodt_state_t s);
    case (s)
      SODT_ST_RUN:  state_code = `SODT_CODE_RUN;
      SODT_ST_STOP: state_code = `SODT_CODE_STOP;
      SODT_ST_SAFE: state_code = `SODT_CODE_SAFE;
      SODT_ST_DOUT: state_code = `SODT_CODE_DELAY_OUT;
      default:      state_code = `SODT_CODE_UNDEF;
    endcase
  endfunction

  // Decode the raw pin under the contact type; a disabled input reads as safe.
  function automatic logic contact_level(input sodt_contact_t c, input logic raw);
    case (c)
      SODT_IN_MAKE:  contact_level = raw;
      SODT_IN_BREAK: contact_level = !raw;
      default:       contact_level = 1'b0;
    endcase
  endfunction

  // ************************************************************
  // Configuration capture
  // ************************************************************
  // Held settings; the delay input stays disabled until a load arrives. [R02]
  // Out-of-range holdoffs are clamped so a bad setting cannot run longer than allowed.
  // A load during delay-out changes the holdoff for the next fall only; the running count stays but takes the new timebase and contact at once.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      contact  <= SODT_IN_DISABLED; // [R02]
      extended <= 1'b0;
      holdoff  <= `SODT_HOLD_RESET;
      tb_sel   <= SODT_TB_BASE;
    end else if (ce_i && cfg_load_i) begin
      contact  <= cfg_contact_i;
      extended <= cfg_extended_i;
      if (!cfg_extended_i) begin
        // Base variant counts 100 ms ticks, at most 6000 of them. [R12] [R19]
        tb_sel  <= SODT_TB_BASE;
        holdoff <= (configured_holdoff_i > `SODT_BASE_MAX_TICKS) ? `SODT_BASE_MAX_TICKS
                                                                  : configured_holdoff_i;
      end else if (configured_holdoff_i <= `SODT_MS1_MAX_MS) begin
        // Fits the 1 ms range: count milliseconds directly, minimum one. [R13] [R14] [R15] [R20]
        tb_sel  <= SODT_TB_1MS;
        holdoff <= (configured_holdoff_i == 20'h00000) ? 20'h00001 : configured_holdoff_i;
      end else begin
        // Longer holdoffs use 10 ms steps up to 600000 ms; the rest is truncated. [R14] [R16] [R20]
        tb_sel  <= SODT_TB_10MS;
        holdoff <= ((configured_holdoff_i > `SODT_MS10_MAX_MS) ? `SODT_MS10_MAX_MS
                                                               : configured_holdoff_i) / 20'd10;
      end
    end
  end

  // ************************************************************
  // Input interpretation
  // ************************************************************
  // Effective level of the delay input. [R01]
  // Contact codes outside the three known ones read as disabled, which is the safe reading.
  assign sm_in = contact_level(contact, delay_input_i);

  // Previous effective level, for the falling edge.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sm_in_d <= 1'b0;
    end else if (ce_i) begin
      sm_in_d <= sm_in;
    end
  end

  assign fall    = sm_in_d && !sm_in;
  assign elapsed = (remain == 20'h00000);

  // ************************************************************
  // Tick prescaler
  // ************************************************************
  // Restart on the fall from run, so the first tick comes a full period after the fall.
  assign tk.sel     = tb_sel;
  assign tk.restart = (state == SODT_ST_RUN) && fall;

  sodt_tick_gen u_tick (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .tk     (tk.gen)
  );

  // ************************************************************
  // State machine
  // ************************************************************
  // Stop overrides all; run on high input; a low input runs out the holdoff.
  // The last count is caught one step ahead, so the output falls on the tick that spends it.
  always_comb begin
    next_state = state;
    if (!block_run_enable_i) begin
      next_state = SODT_ST_STOP; // [R08]
    end else if (sm_in) begin
      next_state = SODT_ST_RUN; // [R04] [R18]
    end else begin
      case (state)
        SODT_ST_RUN:  next_state = (holdoff == 20'h00000) ? SODT_ST_SAFE : SODT_ST_DOUT; // [R05]
        SODT_ST_DOUT: next_state = (elapsed || (remain == 20'h00001 && tk.tick)) ? SODT_ST_SAFE
                                                                                  : SODT_ST_DOUT; // [R06] [R07]
        default:      next_state = SODT_ST_SAFE; // [R07]
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= SODT_ST_UNDEF;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Holdoff counter
  // ************************************************************
  // Loaded on the fall from run, counted down by the tick, abandoned on return to run.
  // The tick is held off in the load cycle, so the first step is always a full period.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      remain <= 20'h00000;
    end else if (ce_i) begin
      if (next_state == SODT_ST_RUN || next_state == SODT_ST_STOP) begin
        remain <= 20'h00000; // [R18]
      end else if (state == SODT_ST_RUN && next_state == SODT_ST_DOUT) begin
        remain <= holdoff; // [R05]
      end else if (state == SODT_ST_DOUT && tk.tick && !elapsed) begin
        remain <= remain - 20'h00001;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Output registered from the next state; only run and delay-out drive it high. [R03] [R04] [R06]
  // Taking the next state keeps the output in step with the state code, with no extra lag.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      delayed_output_o       <= 1'b0;
      holdoff_elapsed_flag_o <= 1'b0;
    end else if (ce_i) begin
      delayed_output_o       <= (next_state == SODT_ST_RUN) || (next_state == SODT_ST_DOUT); // [R03]
      holdoff_elapsed_flag_o <= (next_state == SODT_ST_SAFE); // [R07]
    end
  end

  // No error condition exists in this function. [R11]
  // Tied low on purpose, so no fault can ever be read into this output.
  assign error_o = 1'b0;

  // Process image copy; a word not exposed keeps its last value. [R09] [R10] [R17]
  // The diagnostic word has no source of faults here, so a refresh only rewrites zero.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_code_o      <= `SODT_CODE_UNDEF;
      diagnostic_word_o <= `SODT_DIAG_RESET;
    end else if (ce_i) begin
      if (expose_state_code_i) begin
        state_code_o <= state_code(next_state); // [R09] [R17]
      end
      if (expose_diagnostic_word_i) begin
        diagnostic_word_o <= `SODT_DIAG_RESET; // [R10] [R17]
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  // Helper logic for the checks below; it drives nothing outside this module.
  logic [23:0] tick_due;
  logic [23:0] tick_gap;
  // Terminal count that the selected timebase calls for, worked out afresh from the constants.
  always_comb begin
    case (tb_sel)
      SODT_TB_1MS:  tick_due = 24'(`SODT_CYC_1MS - 1);
      SODT_TB_10MS: tick_due = 24'(`SODT_CYC_10MS - 1);
      default:      tick_due = 24'(`SODT_CYC_BASE - 1);
    endcase
  end
  // Cycles since the prescaler last restarted or ticked. It runs apart from the prescaler, so
  // a prescaler that drifts or loses its terminal compare shows up here at once. [R14]
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tick_gap <= 24'h000000;
    end else if (ce_i) begin
      if (tk.restart || tk.tick) begin
        tick_gap <= 24'h000000;
      end else begin
        tick_gap <= tick_gap + 24'h000001;
      end
    end
  end

  a_stop_forces_low: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R08]
    (ce_i && !block_run_enable_i) |=> (state == SODT_ST_STOP && !delayed_output_o))
    else $error("run enable low did not stop the block");
  a_safe_low_out: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R03]
    (state == SODT_ST_SAFE || state == SODT_ST_STOP) |-> !delayed_output_o)
    else $error("output high in safe or stop state");
  a_run_high_out: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R04]
    (ce_i && block_run_enable_i && sm_in) |=> (state == SODT_ST_RUN && delayed_output_o))
    else $error("high input did not give run with high output");
  a_fall_loads: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R05]
    (ce_i && state == SODT_ST_RUN && block_run_enable_i && !sm_in && holdoff != 20'h00000)
    |=> (state == SODT_ST_DOUT && remain == $past(holdoff)))
    else $error("fall from run did not load the holdoff");
  a_dout_high_out: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R06]
    (state == SODT_ST_DOUT) |-> (delayed_output_o && remain != 20'h00000))
    else $error("delay-out without high output or with spent holdoff");
  a_error_never: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R11]
    !error_o)
    else $error("error output asserted");
  a_diag_zero: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R10]
    diagnostic_word_o == `SODT_DIAG_RESET)
    else $error("diagnostic word not zero");
  a_state_code_copy: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R17]
    (ce_i && expose_state_code_i) |=> (state_code_o == state_code(state)))
    else $error("state code not copied");
  a_state_code_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R17]
    (!expose_state_code_i) |=> $stable(state_code_o))
    else $error("state code changed while not exposed");
  a_return_to_run: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R18]
    (ce_i && state == SODT_ST_DOUT && sm_in && block_run_enable_i)
    |=> (state == SODT_ST_RUN && remain == 20'h00000 && delayed_output_o))
    else $error("holdoff not abandoned on return to run");
  a_disabled_input: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R02]
    (contact == SODT_IN_DISABLED) |-> !sm_in)
    else $error("disabled input seen as active");
  a_base_limit: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R19]
    (!extended) |-> (holdoff <= `SODT_BASE_MAX_TICKS && tb_sel == SODT_TB_BASE))
    else $error("base holdoff above limit");

  // Range, timebase, contact level, delay-out and tick checks.
  a_ext_1ms_range: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R13] [R15]
    (extended && tb_sel == SODT_TB_1MS) |-> (holdoff != 20'h00000 && holdoff <= `SODT_MS1_MAX_MS))
    else $error("1 ms holdoff outside its range");
  a_ext_10ms_range: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R16]
    (extended && tb_sel == SODT_TB_10MS) |-> (holdoff <= (`SODT_MS10_MAX_MS / 20'd10)))
    else $error("10 ms holdoff above limit");
  a_timebase_pick: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R20]
    (ce_i && cfg_load_i && cfg_extended_i)
    |=> (tb_sel == (($past(configured_holdoff_i) <= `SODT_MS1_MAX_MS) ? SODT_TB_1MS : SODT_TB_10MS)))
    else $error("timebase not chosen from the holdoff");
  a_make_level: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R01]
    (contact == SODT_IN_MAKE) |-> (sm_in == delay_input_i))
    else $error("make contact level misread");
  a_break_level: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R01]
    (contact == SODT_IN_BREAK) |-> (sm_in == !delay_input_i))
    else $error("break contact level misread");
  a_dout_stays: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R06]
    (ce_i && state == SODT_ST_DOUT && block_run_enable_i && !sm_in && !tk.tick)
    |=> (state == SODT_ST_DOUT && delayed_output_o))
    else $error("delay-out left before the holdoff ran out");
  a_safe_after_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R07]
    (ce_i && state == SODT_ST_DOUT && block_run_enable_i && !sm_in && remain == 20'h00001 && tk.tick)
    |=> (state == SODT_ST_SAFE && !delayed_output_o && holdoff_elapsed_flag_o))
    else $error("spent holdoff did not give the safe state");
  a_tick_on_time: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R14]
    (ce_i && !tk.restart && tick_gap >= tick_due) |-> tk.tick)
    else $error("timebase tick late");
  a_tick_not_early: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R14]
    (tk.tick) |-> (tick_gap >= tick_due))
    else $error("timebase tick early");

  // Main scenarios: holdoff running, running out, abandoned, and the stop override.
  c_delay_out:  cover property (@(posedge clk_i) disable iff (!nrst_i) state == SODT_ST_DOUT);
  c_dout_safe:  cover property (@(posedge clk_i) disable iff (!nrst_i)
    state == SODT_ST_DOUT ##1 state == SODT_ST_SAFE);
  c_dout_run:   cover property (@(posedge clk_i) disable iff (!nrst_i)
    state == SODT_ST_DOUT ##1 state == SODT_ST_RUN);
  c_stop:       cover property (@(posedge clk_i) disable iff (!nrst_i) state == SODT_ST_STOP);
  c_stop_safe:  cover property (@(posedge clk_i) disable iff (!nrst_i)
    state == SODT_ST_STOP ##1 state == SODT_ST_SAFE);
endmodule // sodt_timer

// file: hdl/sodt_cfg.svh
// Constants of the safe off-delay timer: state codes, limits and timebase counts.
`ifndef SODT_CFG_SVH
`define SODT_CFG_SVH
// ************************************************************
// State codes reported on the 8-bit state word
// ************************************************************
`define SODT_CODE_UNDEF      8'h00
`define SODT_CODE_RUN        8'h01
`define SODT_CODE_STOP       8'h02
`define SODT_CODE_SAFE       8'h03
`define SODT_CODE_DELAY_OUT  8'h08
// ************************************************************
// Diagnostic word and holdoff limits
// ************************************************************
`define SODT_DIAG_RESET      16'h0000
`define SODT_HOLD_RESET      20'h00000
`define SODT_BASE_MAX_TICKS  20'h01770
`define SODT_MS1_MAX_MS      20'h0EA60
`define SODT_MS10_MAX_MS     20'h927C0
// ************************************************************
// Timebase figures, in their own unit, and the clock rate
// ************************************************************
`define SODT_CLK_PERIOD_NS   10
`define SODT_TB_BASE_MS      100
`define SODT_TB_1MS_MS       1
`define SODT_TB_10MS_MS      10
`define SODT_MS_TO_NS        1000000
`define SODT_CYC_BASE        ((`SODT_TB_BASE_MS * `SODT_MS_TO_NS) / `SODT_CLK_PERIOD_NS)
`define SODT_CYC_1MS         ((`SODT_TB_1MS_MS * `SODT_MS_TO_NS) / `SODT_CLK_PERIOD_NS)
`define SODT_CYC_10MS        ((`SODT_TB_10MS_MS * `SODT_MS_TO_NS) / `SODT_CLK_PERIOD_NS)
`endif

// file: hdl/sodt_pkg.sv
// Types shared by the safe off-delay timer modules.
package sodt_pkg;
  // One-hot states of the off-delay machine.
  typedef enum logic [4:0] {
    SODT_ST_UNDEF = 5'h01,
    SODT_ST_RUN   = 5'h02,
    SODT_ST_STOP  = 5'h04,
    SODT_ST_SAFE  = 5'h08,
    SODT_ST_DOUT  = 5'h10
  } sodt_state_t;
  // Contact type of the delay input.
  typedef enum logic [1:0] {
    SODT_IN_DISABLED = 2'h0,
    SODT_IN_MAKE     = 2'h1,
    SODT_IN_BREAK    = 2'h2
  } sodt_contact_t;
  // Timebase selection.
  typedef enum logic [1:0] {
    SODT_TB_BASE = 2'h0,
    SODT_TB_1MS  = 2'h1,
    SODT_TB_10MS = 2'h2
  } sodt_tb_t;
endpackage

// file: hdl/sodt_tick_if.sv
// Interface carrying the timebase tick between prescaler and state machine.
`timescale 1ns/10ps
interface sodt_tick_if;
  import sodt_pkg::*;
  logic     restart;
  sodt_tb_t sel;
  logic     tick;
  modport gen (input restart, input sel, output tick);
  modport use_tick (output restart, output sel, input tick);
endinterface

// file: hdl/sodt_tick_gen.sv
// Timebase prescaler producing a one-cycle tick of 1 ms, 10 ms or 100 ms.
`timescale 1ns/10ps
`include "sodt_cfg.svh"
module sodt_tick_gen
  import sodt_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  // Tick link.
  sodt_tick_if.gen  tk
);
  localparam int unsigned CYC_BASE = `SODT_CYC_BASE;
  localparam int unsigned CYC_1MS  = `SODT_CYC_1MS;
  localparam int unsigned CYC_10MS = `SODT_CYC_10MS;
  logic [23:0] cnt;
  logic [23:0] last;
  // ************************************************************
  // Prescaler
  // ************************************************************
  // Terminal count follows the selected timebase.
  always_comb begin
    case (tk.sel)
      SODT_TB_1MS:  last = 24'(CYC_1MS - 1);
      SODT_TB_10MS: last = 24'(CYC_10MS - 1);
      default:      last = 24'(CYC_BASE - 1);
    endcase
  end
  // Restart aligns the first tick to a full period after the input falls.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt <= 24'h000000;
    end else if (ce_i) begin
      if (tk.restart || cnt >= last) begin
        cnt <= 24'h000000;
      end else begin
        cnt <= cnt + 24'h000001;
      end
    end
  end
  assign tk.tick = ce_i && !tk.restart && (cnt >= last);
endmodule // sodt_tick_gen

// file: testbench/sodt_src_model.sv
// Upstream safety input model that drives the raw delay input of the timer.
`timescale 1ns/10ps
module sodt_src_model (
  // Clock.
  input  wire logic clk_i,
  // Request from the bench: logical activity and contact wiring.
  input  wire logic active_i,
  input  wire logic break_i,
  // Raw level toward the timer.
  output logic      delay_input_o
);
  // Start from a defined low level so the timer never sees an unknown input.
  initial delay_input_o = 1'b0;
  // One cycle of upstream latency; a break contact carries the inverse level.
  always @(posedge clk_i) begin
    delay_input_o <= active_i ^ break_i;
  end
endmodule // sodt_src_model

// file: testbench/tb_sodt_timer.sv
// Self-checking testbench of the safe off-delay timer.
`timescale 1ns/10ps
`include "sodt_cfg.svh"
module tb_sodt_timer;
  import sodt_pkg::*;
  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic          clk_i    = 1'b0;
  logic          nrst_i   = 1'b0;
  logic          ce_i     = 1'b1;
  logic          active   = 1'b1;
  logic          brk      = 1'b0;
  logic          raw_in;
  logic          run_en   = 1'b0;
  logic          cfg_load = 1'b0;
  sodt_contact_t contact  = SODT_IN_DISABLED;
  logic          ext      = 1'b0;
  logic [19:0]   holdoff  = 20'h00000;
  logic          exp_st   = 1'b1;
  logic          exp_dg   = 1'b1;
  logic          dout;
  logic          err;
  logic          flag;
  logic [7:0]    code;
  logic [15:0]   diag;
  int            fail_count   = 0;
  int            total_checks = 0;
  int            n;
  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;
  // ************************************************************
  // Device and upstream model
  // ************************************************************
  sodt_src_model src (.clk_i(clk_i), .active_i(active), .break_i(brk), .delay_input_o(raw_in));
  sodt_timer dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .delay_input_i(raw_in), .block_run_enable_i(run_en),
    .cfg_load_i(cfg_load), .cfg_contact_i(contact), .cfg_extended_i(ext), .configured_holdoff_i(holdoff),
    .expose_state_code_i(exp_st), .expose_diagnostic_word_i(exp_dg), .delayed_output_o(dout),
    .error_o(err), .holdoff_elapsed_flag_o(flag), .state_code_o(code), .diagnostic_word_o(diag));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: saw %0h, expected %0h", $time, seen, want);
    end
  endtask
  // Compares the state word, the output and the two words that must stay quiet.
  task automatic expect_st(input logic [7:0] c, input logic o, input logic f);
    check(20'(code), 20'(c));
    check(20'(dout), 20'(o));
    check(20'(flag), 20'(f));
    check(20'(err), 20'h00000);
    check(20'(diag), 20'h00000);
  endtask
  // Loads a configuration; the model rewires the contact at the same edge.
  task automatic configure(input sodt_contact_t c, input logic e, input logic [19:0] h);
    contact  = c;
    ext      = e;
    holdoff  = h;
    brk      = (c == SODT_IN_BREAK);
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
  endtask
  // The upstream model adds one cycle, the timer one more.
  task automatic drive(input logic a);
    active = a;
    cyc(2);
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog: the tests take about 100040 cycles, so 101000 leaves room for the search window.
  initial begin
    #1010000;
    fail_count++;
    final_report();
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    cyc(3);
    expect_st(`SODT_CODE_UNDEF, 1'b0, 1'b0);
    nrst_i = 1'b1;
    run_en = 1'b1;
    cyc(2);
    // The raw input is high, but an unconfigured contact reads inactive.
    expect_st(`SODT_CODE_SAFE, 1'b0, 1'b1);
    $display("test unconfigured done");
    configure(SODT_IN_MAKE, 1'b1, 20'h00001);
    cyc(1);
    expect_st(`SODT_CODE_RUN, 1'b1, 1'b0);
    drive(1'b0);
    expect_st(`SODT_CODE_DELAY_OUT, 1'b1, 1'b0);
    cyc(5);
    drive(1'b1);
    expect_st(`SODT_CODE_RUN, 1'b1, 1'b0);
    $display("test make contact done");
    run_en = 1'b0;
    exp_dg = 1'b0;
    cyc(1);
    expect_st(`SODT_CODE_STOP, 1'b0, 1'b0);
    run_en = 1'b1;
    cyc(1);
    expect_st(`SODT_CODE_RUN, 1'b1, 1'b0);
    // Clock enable low freezes everything, even a stop request.
    ce_i   = 1'b0;
    run_en = 1'b0;
    cyc(2);
    expect_st(`SODT_CODE_RUN, 1'b1, 1'b0);
    // With the state word unexposed it keeps its last value.
    exp_st = 1'b0;
    ce_i   = 1'b1;
    cyc(1);
    check(20'(code), 20'(`SODT_CODE_RUN));
    check(20'(dout), 20'h00000);
    exp_st = 1'b1;
    exp_dg = 1'b1;
    cyc(1);
    expect_st(`SODT_CODE_STOP, 1'b0, 1'b0);
    // A low input while stopped leads to safe, not to a holdoff, once the block runs again.
    drive(1'b0);
    run_en = 1'b1;
    cyc(1);
    expect_st(`SODT_CODE_SAFE, 1'b0, 1'b1);
    $display("test stop and image done");
    // Break contact: a low raw level is the active one.
    configure(SODT_IN_BREAK, 1'b0, 20'h00000);
    drive(1'b1);
    check(20'(raw_in), 20'h00000);
    expect_st(`SODT_CODE_RUN, 1'b1, 1'b0);
    drive(1'b0);
    expect_st(`SODT_CODE_SAFE, 1'b0, 1'b1);
    $display("test break contact done");
    // Shortest extended holdoff: one 1 ms tick of 100000 cycles.
    configure(SODT_IN_MAKE, 1'b1, 20'h00001);
    drive(1'b1);
    expect_st(`SODT_CODE_RUN, 1'b1, 1'b0);
    drive(1'b0);
    cyc(99990);
    expect_st(`SODT_CODE_DELAY_OUT, 1'b1, 1'b0);
    n = 99990;
    while (code !== `SODT_CODE_SAFE && n < 100010) begin
      cyc(1);
      n++;
    end
    expect_st(`SODT_CODE_SAFE, 1'b0, 1'b1);
    check(20'((n >= 99998) && (n <= 100002)), 20'h00001);
    $display("test timed holdoff done");
    // Out-of-range settings are clamped and leave a settled block alone.
    configure(SODT_IN_MAKE, 1'b1, 20'hFFFFF);
    cyc(1);
    configure(SODT_IN_MAKE, 1'b0, 20'hFFFFF);
    cyc(1);
    expect_st(`SODT_CODE_SAFE, 1'b0, 1'b1);
    $display("test clamped settings done");
    final_report();
  end
endmodule // tb_sodt_timer
